// ===== mrc_pkg.sv
// package for the monitor result and control register bank
package mrc_pkg;
    // ------------------------------------------------------------------
    // group indexes, six bytes per group
    // ------------------------------------------------------------------
    localparam logic [2:0] GRP_AUX_C   = 3'h0;
    localparam logic [2:0] GRP_AUX_D   = 3'h1;
    localparam logic [2:0] GRP_STAT_A  = 3'h2;
    localparam logic [2:0] GRP_STAT_B  = 3'h3;
    localparam logic [2:0] GRP_XFER    = 3'h4;
    localparam logic [2:0] GRP_SPIN    = 3'h5;
    localparam logic [2:0] GRP_DUTY    = 3'h6;
    localparam logic [2:0] GRP_DS_B    = 3'h7;
    localparam int         GRP_BYTES   = 6;
    // ------------------------------------------------------------------
    // own interrupt registers in the spare bytes 6 and 7 of group 0,
    // so they never shadow a mapped group byte
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_IRQ_STAT = 6'h06;
    localparam logic [5:0] ADDR_IRQ_MASK = 6'h07;
    // interrupt bits: results, flags, limit change
    localparam int         IRQ_RES_BIT   = 0;
    localparam int         IRQ_FLT_BIT   = 1;
    localparam int         IRQ_LIM_BIT   = 2;
    localparam logic [7:0] RSV_ONES      = 8'hFF;
    localparam logic [3:0] RSV_NIB_ONES  = 4'hF;
    localparam logic [7:0] RW_RESET      = 8'h00;
endpackage

// ===== mrc_regs.sv
// register bank for result, status, transfer, s-pin and duty groups
// Behaviour
// - aux group C read-only: inputs 6..8 as 16-bit, low byte first
// - aux group D: input 9, bytes 2-3 and byte5 high nibble read ones
// - status A read-only: stack sum, die temperature, analog supply
// - status B: digital supply, cell 1-12 flags, revision, fault bits
// - transfer group rw: three entries, lead code, data, trail code
// - s-pin group rw: cells 1-12 nibbles, odd cell low nibble
// - duty group rw: cells 1-12 nibbles, odd cell low nibble
// - combined group rw: duty then s-pin nibbles for cells 13-18
//
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module mrc_regs
    import mrc_pkg::*;
#(
    parameter int NUM_RW = 24
) (
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    // register port
    input  wire logic [5:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    // measurement results from the converter
    input  wire logic [15:0] aux_input6_result_in,
    input  wire logic [15:0] aux_input7_result_in,
    input  wire logic [15:0] aux_input8_result_in,
    input  wire logic [15:0] aux_input9_result_in,
    input  wire logic [15:0] stack_sum_in,
    input  wire logic [15:0] die_temperature_in,
    input  wire logic [15:0] analog_supply_value_in,
    input  wire logic [15:0] digital_supply_value_in,
    input  wire logic        results_upd_in,
    // per cell flags, index 0 is cell 1
    input  wire logic [17:0] cell_under_flag_in,
    input  wire logic [17:0] cell_over_flag_in,
    input  wire logic        mux_fault_flag_in,
    input  wire logic        thermal_shutdown_flag_in,
    input  wire logic [3:0]  revision_in,
    // control values to the cell and master-port logic
    output logic      [3:0]  leading_control_code_out [3],
    output logic      [7:0]  transfer_data_byte_out [3],
    output logic      [3:0]  trailing_control_code_out [3],
    output logic      [3:0]  s_pin_control_nibble_out [18],
    output logic      [3:0]  balance_duty_nibble_out [18],
    // interrupt
    output logic             irq_out
);
    // the byte map below is fixed, so only the documented depth is served
    generate
        if (NUM_RW != 24) begin : g_bad_depth
            $error("mrc_regs: NUM_RW must be 24");
        end
    endgenerate

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // groups are eight bytes apart, index 0..5 inside each
    wire logic [2:0] grp_sel  = addr_in[5:3];
    wire logic [2:0] byte_sel = addr_in[2:0];
    wire logic       byte_ok  = (byte_sel < 3'(GRP_BYTES));
    wire logic       is_own   = (addr_in == ADDR_IRQ_STAT) ||
                                (addr_in == ADDR_IRQ_MASK);
    // writable bytes: transfer, s-pin, duty and combined groups only
    wire logic       rw_grp   = (grp_sel >= GRP_XFER) && !is_own;
    // ro groups never take a write
    wire logic       rw_hit   = wr_in && rw_grp && byte_ok;
    wire logic [4:0] rw_idx   = 5'(({2'h0, grp_sel} - 5'h4) * 5'h6)
                              + {2'h0, byte_sel};

    // ------------------------------------------------------------------
    // writable storage, 24 bytes
    // ------------------------------------------------------------------
    logic [7:0] rw_q [NUM_RW];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_RW; gi++) begin : g_rw
            // one byte register per entry
            always_ff @(posedge core_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    rw_q[gi] <= RW_RESET;
                end else if (rw_hit && rw_idx == 5'(gi)) begin
                    rw_q[gi] <= wdata_in;
                end
            end
        end
        // transfer entries: head = lead code | data high, tail = data low | trail code
        for (gi = 0; gi < 3; gi++) begin : g_xfer
            assign leading_control_code_out[gi] = rw_q[2*gi][7:4];
            assign transfer_data_byte_out[gi]   =
                {rw_q[2*gi][3:0], rw_q[2*gi+1][7:4]};
            assign trailing_control_code_out[gi] = rw_q[2*gi+1][3:0];
        end
        // odd cell low nibble, even cell high nibble
        for (gi = 0; gi < 6; gi++) begin : g_cell
            assign s_pin_control_nibble_out[2*gi]   = rw_q[6+gi][3:0];
            assign s_pin_control_nibble_out[2*gi+1] = rw_q[6+gi][7:4];
            assign balance_duty_nibble_out[2*gi]    = rw_q[12+gi][3:0];
            assign balance_duty_nibble_out[2*gi+1]  = rw_q[12+gi][7:4];
        end
        for (gi = 0; gi < 3; gi++) begin : g_cell_b
            assign balance_duty_nibble_out[12+2*gi]   = rw_q[18+gi][3:0];
            assign balance_duty_nibble_out[13+2*gi]   = rw_q[18+gi][7:4];
            assign s_pin_control_nibble_out[12+2*gi]  = rw_q[21+gi][3:0];
            assign s_pin_control_nibble_out[13+2*gi]  = rw_q[21+gi][7:4];
        end
    endgenerate

    // ------------------------------------------------------------------
    // flag packing: under flag in the lower bit of each pair
    // ------------------------------------------------------------------
    logic [35:0] lim_pairs;
    generate
        for (gi = 0; gi < 18; gi++) begin : g_pair
            assign lim_pairs[2*gi]   = cell_under_flag_in[gi];
            assign lim_pairs[2*gi+1] = cell_over_flag_in[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // read-only group byte selection
    // ------------------------------------------------------------------
    wire logic [7:0] aux_c_b [6] = '{
        aux_input6_result_in[7:0], aux_input6_result_in[15:8],
        aux_input7_result_in[7:0], aux_input7_result_in[15:8],
        aux_input8_result_in[7:0], aux_input8_result_in[15:8]};
    wire logic [7:0] aux_d_b [6] = '{
        aux_input9_result_in[7:0], aux_input9_result_in[15:8],
        RSV_ONES, RSV_ONES, lim_pairs[31:24],
        {RSV_NIB_ONES, lim_pairs[35:32]}};
    wire logic [7:0] stat_a_b [6] = '{
        stack_sum_in[7:0], stack_sum_in[15:8],
        die_temperature_in[7:0], die_temperature_in[15:8],
        analog_supply_value_in[7:0],
        analog_supply_value_in[15:8]};
    // reserved bits 3:2 of the last byte read zero
    wire logic [7:0] stat_b_b [6] = '{
        digital_supply_value_in[7:0], digital_supply_value_in[15:8],
        lim_pairs[7:0], lim_pairs[15:8], lim_pairs[23:16],
        {revision_in, 2'b00, mux_fault_flag_in,
         thermal_shutdown_flag_in}};

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    logic [2:0]  irq_stat_q;
    logic [2:0]  irq_stat_d;
    logic [2:0]  irq_mask_q;
    logic [2:0]  flt_q;
    logic [35:0] lim_q;
    wire logic [2:0] irq_evt = {
        (lim_pairs != lim_q),
        ({mux_fault_flag_in, thermal_shutdown_flag_in} != flt_q[1:0]),
        results_upd_in};
    wire logic [2:0] irq_clr =
        (wr_in && addr_in == ADDR_IRQ_STAT) ? wdata_in[2:0] : 3'h0;
    // a set in the clearing cycle wins so no event is lost
    assign irq_stat_d = (irq_stat_q & ~irq_clr) | irq_evt;
    assign irq_out    = |(irq_stat_q & irq_mask_q);

    // event history and interrupt registers
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
            flt_q      <= 3'h0;
            lim_q      <= '0;
        end else begin
            irq_stat_q <= irq_stat_d;
            flt_q      <= {1'b0, mux_fault_flag_in, thermal_shutdown_flag_in};
            lim_q      <= lim_pairs;
            if (wr_in && addr_in == ADDR_IRQ_MASK) begin
                irq_mask_q <= wdata_in[2:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // read mux; unmapped bytes read zero
    // ------------------------------------------------------------------
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (addr_in == ADDR_IRQ_STAT) begin
            rd_mux = {5'h00, irq_stat_q};
        end else if (addr_in == ADDR_IRQ_MASK) begin
            rd_mux = {5'h00, irq_mask_q};
        end else if (byte_ok && !is_own) begin
            case (grp_sel)
                GRP_AUX_C:  rd_mux = aux_c_b[byte_sel];
                GRP_AUX_D:  rd_mux = aux_d_b[byte_sel];
                GRP_STAT_A: rd_mux = stat_a_b[byte_sel];
                GRP_STAT_B: rd_mux = stat_b_b[byte_sel];
                default:    rd_mux = rw_q[rw_idx];
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rd_in ? rd_mux : 8'h00;
        end
    end
endmodule // mrc_regs

// ===== mrc_regs_properties.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module mrc_regs_properties #(
    parameter int NUM_RW = 24
) (
    input wire logic        core_clk_in,
    input wire logic        rst_b_in,
    input wire logic [5:0]  addr_in,
    input wire logic [7:0]  wdata_in,
    input wire logic        wr_in,
    input wire logic        rd_in,
    input wire logic [7:0]  rdata_out,
    input wire logic [15:0] aux_input6_result_in,
    input wire logic        mux_fault_flag_in,
    input wire logic        thermal_shutdown_flag_in,
    input wire logic [3:0]  revision_in,
    input wire logic [3:0]  leading_control_code_out [3],
    input wire logic [7:0]  transfer_data_byte_out [3],
    input wire logic [3:0]  s_pin_control_nibble_out [18],
    input wire logic [3:0]  balance_duty_nibble_out [18]
);
    // one clock domain, reset quiets every check
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    AST_RD_IDLE: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data not idle");
    AST_AUX6_LO: assert property (rd_in && addr_in == 6'h00 |=>
        rdata_out == $past(aux_input6_result_in[7:0])) else $error("aux6 low");
    AST_PAD_ONES: assert property (rd_in && addr_in[5:1] == 5'h05 |=>
        rdata_out == 8'hFF) else $error("padding not ones");
    AST_STATB_TOP: assert property (rd_in && addr_in == 6'h1D |=>
        rdata_out == {revision_in, 2'b00, mux_fault_flag_in,
        thermal_shutdown_flag_in}) else $error("status top byte");
    AST_XFER_HEAD: assert property (wr_in && addr_in == 6'h20 |=>
        {leading_control_code_out[0], transfer_data_byte_out[0][7:4]}
        == $past(wdata_in)) else $error("transfer head byte");
    AST_SPIN_PAIR: assert property (wr_in && addr_in == 6'h28 |=>
        {s_pin_control_nibble_out[1], s_pin_control_nibble_out[0]}
        == $past(wdata_in)) else $error("s-pin pair order");
    AST_DUTY_PAIR: assert property (wr_in && addr_in == 6'h30 |=>
        {balance_duty_nibble_out[1], balance_duty_nibble_out[0]}
        == $past(wdata_in)) else $error("duty pair order");
    AST_DSB_SPIN: assert property (wr_in && addr_in == 6'h3B |=>
        {s_pin_control_nibble_out[13], s_pin_control_nibble_out[12]}
        == $past(wdata_in)) else $error("upper s-pin pair");
endmodule // mrc_regs_properties
bind mrc_regs mrc_regs_properties #(.NUM_RW(NUM_RW)) prop_u (.*);

// ===== mrc_host_model.sv
// host model that drives the byte register port
`timescale 1ns/1ps
module mrc_host_model (
    input  wire logic       core_clk_in,
    output logic      [5:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            wr_out,
    output logic            rd_out,
    input  wire logic [7:0] rdata_in
);
    logic [7:0] got;
    // --------------------------------
    // one-edge strobes, then an idle edge so no strobe re-arms in one step
    // --------------------------------
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge core_clk_in);
        wr_out <= 1'b0;
        wdata_out <= ~d; // released data must not look held
        @(posedge core_clk_in);
    endtask
    task automatic rd(input logic [5:0] a);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge core_clk_in);
        rd_out <= 1'b0;
        #1 got = rdata_in; // reply stands only in this cycle
        @(posedge core_clk_in);
    endtask
    initial begin
        {addr_out, wdata_out, wr_out, rd_out} = '0;
    end
endmodule // mrc_host_model

// ===== mrc_regs_bench.sv
// self-checking bench for the result and control register bank
`timescale 1ns/1ps
module mrc_regs_bench;
    import mrc_pkg::*;
    logic        clk, rst_b, wr, rd, upd, mux, thermal_shutdown_flag, irq;
    logic [5:0]  addr;
    logic [7:0]  wdata, rdata, v, xd [3];
    logic [15:0] res [8];
    logic [17:0] uv, ov;
    logic [3:0]  rev, ld [3], tr [3], sp [18], du [18];
    int          error_cnt, cmp_count;
    mrc_regs dut_u (.core_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .aux_input6_result_in(res[0]), .aux_input7_result_in(res[1]),
        .aux_input8_result_in(res[2]), .aux_input9_result_in(res[3]),
        .stack_sum_in(res[4]), .die_temperature_in(res[5]),
        .analog_supply_value_in(res[6]), .digital_supply_value_in(res[7]),
        .results_upd_in(upd), .cell_under_flag_in(uv),
        .cell_over_flag_in(ov), .mux_fault_flag_in(mux),
        .thermal_shutdown_flag_in(thermal_shutdown_flag), .revision_in(rev),
        .leading_control_code_out(ld), .transfer_data_byte_out(xd),
        .trailing_control_code_out(tr), .s_pin_control_nibble_out(sp),
        .balance_duty_nibble_out(du), .irq_out(irq));
    mrc_host_model host_u (.core_clk_in(clk), .addr_out(addr),
        .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .rdata_in(rdata));
    // --------------------------------
    // expected values
    // --------------------------------
    function automatic logic [7:0] pat(input int a);
        return 8'(a * 37 + 60);
    endfunction
    function automatic logic [7:0] fl(input int c);
        return {ov[c+3], uv[c+3], ov[c+2], uv[c+2],
                ov[c+1], uv[c+1], ov[c], uv[c]};
    endfunction
    function automatic logic [7:0] ro(input int g, input int b);
        logic [15:0] w;
        w = res[g == 0 ? b / 2 : g == 1 ? 3 : g == 2 ? 4 + b / 2 : 7];
        if (g == 0 || g == 2 || b < 2) return b % 2 ? w[15:8] : w[7:0];
        if (g == 3) return b < 5 ? fl(4 * b - 8) : {rev, 2'b00, mux, thermal_shutdown_flag};
        return b < 4 ? 8'hFF : b == 4 ? fl(12)
                     : {4'hF, ov[17], uv[17], ov[16], uv[16]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (error_cnt == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_results();
        for (int i = 0; i < 8; i++) res[i] <= 16'(16'hA51C + 16'h1111 * i);
        {uv, ov, rev, mux, thermal_shutdown_flag, upd} <= {18'h2A5C3, 18'h1963A, 4'h9, 3'h5};
        @(posedge clk);
        upd <= 1'b0;
        for (int a = 0; a < 32; a++) if (a % 8 < 6) begin
            host_u.rd(6'(a));
            check(host_u.got, ro(a / 8, a % 8));
        end
    endtask
    task automatic t_rw();
        for (int a = 32; a < 64; a++) if (a % 8 < 6) host_u.wr(6'(a), pat(a));
        host_u.wr(6'h02, 8'h00); // read-only target, must be ignored
        host_u.wr(6'h26, 8'h5A);
        for (int a = 0; a < 64; a++) begin
            host_u.rd(6'(a));
            check(host_u.got, a == 6 ? 8'h07 : a % 8 > 5 ? 8'h00
                  : a < 32 ? ro(a / 8, a % 8)
                  : pat(a));
        end
        for (int i = 0; i < 3; i++) begin
            check({ld[i], xd[i][7:4]}, pat(32 + 2 * i));
            check({xd[i][3:0], tr[i]}, pat(33 + 2 * i));
        end
        for (int c = 0; c < 18; c++) begin
            v = pat(c < 12 ? 40 + c / 2 : 53 + c / 2);
            check({4'h0, sp[c]}, {4'h0, c % 2 ? v[7:4] : v[3:0]});
            v = pat(c < 12 ? 48 + c / 2 : 50 + c / 2);
            check({4'h0, du[c]}, {4'h0, c % 2 ? v[7:4] : v[3:0]});
        end
    endtask
    // events are pending from t_results; mask off so no interrupt yet
    task automatic t_irq();
        check({7'h00, irq}, 8'h00);
        host_u.wr(ADDR_IRQ_MASK, 8'h07);
        check({7'h00, irq}, 8'h01);
        host_u.wr(ADDR_IRQ_STAT, 8'h07);
        host_u.rd(ADDR_IRQ_STAT);
        check(host_u.got, 8'h00);
        check({7'h00, irq}, 8'h00);
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        {rst_b, upd, mux, thermal_shutdown_flag, rev, uv, ov} = '0;
        foreach (res[i]) res[i] = '0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_results();
        t_rw();
        t_irq();
        give_verdict();
    end
    // hang guard, well past the ~250 cycles the scenarios take
    initial begin
        repeat (3000) @(posedge clk);
        error_cnt++;
        give_verdict();
    end
endmodule // mrc_regs_bench
